/* File: hdl/ubg_baud_gen.sv */
// Baud rate generator: prescaler and reloading divisor down-counter
`timescale 1ns/1ps
module ubg_baud_gen #(
	parameter int PRE_HS8 = 16,
	parameter int PRE_HS16 = 16
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic restart,
	input wire logic [7:0] divLo,
	input wire logic [7:0] divHi,
	input wire ubg_pkg::ubg_baud_cfg_t cfg,
	output logic tick
);
	import ubg_pkg::*;

	if (PRE_HS8 < 1 || PRE_HS8 > PRE_MAX || PRE_HS16 < 1 || PRE_HS16 > PRE_MAX)
	begin : g_bad_pre
		$error("High speed prescale must be 1 to 64");
	end

	// ----------------------------------------------------------------
	// Mode decode
	// ----------------------------------------------------------------
	function automatic logic [6:0] preSelect(input ubg_baud_cfg_t c);
		if (c.sync)
			preSelect = 7'(PRE_SYNC); // [R10] [R12]
		else if (!c.highSpeed)
			preSelect = c.wide ? 7'(PRE_ASYNC_WIDE) : 7'(PRE_ASYNC_NARROW); // [R8] [R9]
		else
			// High speed factors stay parameters until confirmed
			preSelect = c.wide ? 7'(PRE_HS16) : 7'(PRE_HS8); // [R15]
	endfunction : preSelect

	wire [6:0] preMax = preSelect(cfg);
	wire [15:0] divEff = cfg.wide ? {divHi, divLo} : {8'h00, divLo}; // [R6] [R7] [R13]
	logic [5:0] pre;
	logic [15:0] cnt;
	// Compare with >= so a mode change mid-count cannot overrun the prescaler
	wire preLast = {1'b0, pre} >= (preMax - 7'd1);

	// ----------------------------------------------------------------
	// Counters
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			pre <= 6'h00;
			cnt <= 16'h0000;
			tick <= 1'b0;
		end
		else if (restart)
		begin
			pre <= 6'h00; // [R4] [R5]
			cnt <= divEff; // [R4] [R5]
			tick <= 1'b0;
		end
		else
		begin
			pre <= preLast ? 6'h00 : pre + 6'h01;
			if (preLast)
				cnt <= (cnt == 16'h0000) ? divEff : cnt - 16'h0001; // [R14]
			tick <= preLast && (cnt == 16'h0000); // [R14]
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	logic [23:0] gap;
	logic gapOk;
	logic [22:0] lastKey;
	wire [22:0] key = {preMax, divEff};

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			gap <= 24'h00_0000;
			gapOk <= 1'b0;
			lastKey <= 23'h00_0000;
		end
		else
		begin
			gap <= tick ? 24'h00_0001 : gap + 24'h00_0001;
			lastKey <= key;
			if (restart || key != lastKey)
				gapOk <= 1'b0;
			else if (tick)
				gapOk <= 1'b1;
		end
	end

	a_bit_period: assert property (@(posedge clk_sys) disable iff (!nrst) // [R8] [R9] [R10] [R14]
		(tick && gapOk && !restart && key == lastKey)
		|-> (gap == 24'(preMax) * (24'(divEff) + 24'h00_0001)))
		else $error("Tick spacing differs from prescale times n+1");

	a_restart_reload: assert property (@(posedge clk_sys) disable iff (!nrst) // [R4] [R5]
		restart |=> (pre == 6'h00 && cnt == $past(divEff) && !tick))
		else $error("Restart did not reload the counter");

	a_wide_divisor: assert property (@(posedge clk_sys) disable iff (!nrst) // [R7]
		(restart && cfg.wide) |=> (cnt == {$past(divHi), $past(divLo)}))
		else $error("Wide divisor not formed from high and low bytes");

	a_narrow_divisor: assert property (@(posedge clk_sys) disable iff (!nrst) // [R6]
		(restart && !cfg.wide) |=> (cnt[15:8] == 8'h00 && cnt[7:0] == $past(divLo)))
		else $error("High divisor byte used while narrow");

	a_mode_prescale: assert property (@(posedge clk_sys) disable iff (!nrst) // [R12]
		cfg.sync |-> (preMax == 7'h04))
		else $error("Synchronous prescale is not four");

endmodule : ubg_baud_gen

/* File: hdl/ubg_buffers.sv */
// Serial port data buffers, divisor registers, flags and Wishbone slave
`timescale 1ns/1ps
// Summary of operation
// R1 - Receive buffer read gives the low eight bits; ninth bit is in receive status.
// R2 - Receive holding buffer, ninth bit too, stays readable while next character shifts.
// R3 - Transmit buffer, ninth bit too, reloadable once previous character started shifting.
// R4 - Writing the low divisor byte restarts the baud counter.
// R5 - Writing the high divisor byte restarts the baud counter.
// R6 - High divisor byte ignored unless wide divisor select is set.
// R7 - Wide divisor is high byte above low byte.
// R8 - Async narrow low speed: rate is clock over 64 times n+1.
// R9 - Async wide low speed: rate is clock over 16 times n+1.
// R10 - Synchronous: rate is clock over 4 times n+1, high speed ignored.
// R11 - Each channel has receive and transmit flags with matching enables.
// R12 - Mode select set means synchronous, cleared means asynchronous.
// R13 - Wide divisor select chooses 16-bit counting, else 8-bit.
// R14 - Down-counter reloads n at zero, one tick per n+1 prescaled periods.
// R15 - Async high speed factors are settable, not assumed.
module ubg_buffers #(
	parameter int PRE_HS8 = 16,
	parameter int PRE_HS16 = 16
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ubg_pkg::ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic irq,
	input wire logic rxCharValid,
	input wire ubg_pkg::ubg_rx_char_t rxChar,
	output logic txCharValid,
	output ubg_pkg::ubg_tx_char_t txChar,
	input wire logic txCharTake,
	input wire logic shiftEmpty,
	input wire logic rxIdle,
	input wire logic ch2RxEvent,
	input wire logic ch2TxEvent,
	output ubg_pkg::ubg_port_cfg_t portCfg,
	output logic baudTick
);
	import ubg_pkg::*;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] putBit(input logic [7:0] v, input int pos, input logic b);
		putBit = v;
		putBit[pos] = b;
	endfunction : putBit

	function automatic logic [7:0] maskedWrite(input logic [7:0] old, input logic [7:0] d,
		input logic [7:0] m, input logic en);
		maskedWrite = en ? (d & m) : old;
	endfunction : maskedWrite

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [7:0] txCtl;
	logic [7:0] rxCtl;
	logic [7:0] baudCtl;
	logic [7:0] divLo;
	logic [7:0] divHi;
	logic [7:0] flag;
	logic [7:0] enable;
	ubg_rx_char_t rxHold;
	logic rxFull;
	logic overrun;
	ubg_tx_char_t txBuf;
	logic txFull;
	logic divRestart;

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	wire [7:0] wordAdr = {wb_adr_i[7:2], 2'b00};
	wire busReq = wb_cyc_i && wb_stb_i;
	wire wbWr = busReq && wb_we_i && wb_ack_o && wb_sel_i[0];
	wire wbRd = busReq && !wb_we_i && wb_ack_o;
	wire rxRead = wbRd && (wordAdr == ADR_RX_DATA);
	wire txWr = wbWr && (wordAdr == ADR_TX_DATA);
	wire divLoWr = wbWr && (wordAdr == ADR_DIV_LOW);
	wire divHiWr = wbWr && (wordAdr == ADR_DIV_HIGH);
	wire rxStatWr = wbWr && (wordAdr == ADR_RX_STAT);
	wire txStatWr = wbWr && (wordAdr == ADR_TX_STAT);
	wire baudWr = wbWr && (wordAdr == ADR_BAUD_CTL);
	wire flagWr = wbWr && (wordAdr == ADR_FLAG);
	wire enableWr = wbWr && (wordAdr == ADR_ENABLE);
	wire [7:0] wrByte = wb_dat_i[7:0];

	// ----------------------------------------------------------------
	// Read views
	// ----------------------------------------------------------------
	wire [7:0] txStatView = putBit(txCtl & TX_STAT_WMASK, TX_SHIFT_EMPTY, shiftEmpty);
	wire [7:0] rxStatBase = putBit(rxCtl & RX_STAT_WMASK, RX_FRAME_ERR, rxHold.frameErr);
	wire [7:0] rxStatMid = putBit(rxStatBase, RX_OVERRUN, overrun);
	wire [7:0] rxStatView = putBit(rxStatMid, RX_NINTH, rxHold.ninth); // [R1]
	wire [7:0] baudView = putBit(baudCtl & BAUD_WMASK, BAUD_RX_IDLE, rxIdle);
	wire [7:0] rdByte =
		(wordAdr == ADR_RX_DATA) ? rxHold.data : // [R1]
		(wordAdr == ADR_TX_DATA) ? txBuf.data :
		(wordAdr == ADR_DIV_LOW) ? divLo :
		(wordAdr == ADR_DIV_HIGH) ? divHi :
		(wordAdr == ADR_RX_STAT) ? rxStatView :
		(wordAdr == ADR_TX_STAT) ? txStatView :
		(wordAdr == ADR_BAUD_CTL) ? baudView :
		(wordAdr == ADR_FLAG) ? flag :
		(wordAdr == ADR_ENABLE) ? enable : 8'h00;

	// ----------------------------------------------------------------
	// Wishbone slave
	// ----------------------------------------------------------------
	// One wait state keeps read data registered
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end
		else
		begin
			wb_ack_o <= busReq && !wb_ack_o;
			if (busReq && !wb_we_i && !wb_ack_o)
				wb_dat_o <= {24'h00_0000, rdByte};
		end
	end

	// ----------------------------------------------------------------
	// Receive holding buffer
	// ----------------------------------------------------------------
	// New arrival wins over a same-cycle read so no character is lost
	wire next_rxFull = rxCharValid || (rxFull && !rxRead); // [R2]
	wire overrunSet = rxCharValid && rxFull && !rxRead;
	// Overrun clears only while continuous receive is off
	wire next_overrun = overrunSet || (overrun && rxCtl[RX_CONT_EN]);

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			rxHold <= '0;
			rxFull <= 1'b0;
			overrun <= 1'b0;
		end
		else
		begin
			if (rxCharValid)
				rxHold <= rxChar; // [R2]
			rxFull <= next_rxFull;
			overrun <= next_overrun;
		end
	end

	// ----------------------------------------------------------------
	// Transmit buffer
	// ----------------------------------------------------------------
	// A write while full replaces the waiting character
	wire txTaken = txFull && txCharTake;
	wire next_txFull = txWr || (txFull && !txCharTake); // [R3]

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			txBuf <= '0;
			txFull <= 1'b0;
		end
		else
		begin
			if (txWr)
				txBuf <= '{ninth: txCtl[TX_NINTH], data: wrByte}; // [R3]
			txFull <= next_txFull;
		end
	end

	assign txCharValid = txFull;
	assign txChar = txBuf;

	// ----------------------------------------------------------------
	// Control and divisor registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			txCtl <= TX_STAT_RST;
			rxCtl <= RX_STAT_RST;
			baudCtl <= BAUD_RST;
			divLo <= DIV_RST;
			divHi <= DIV_RST;
			divRestart <= 1'b0;
		end
		else
		begin
			txCtl <= maskedWrite(txCtl, wrByte, TX_STAT_WMASK, txStatWr);
			rxCtl <= maskedWrite(rxCtl, wrByte, RX_STAT_WMASK, rxStatWr);
			baudCtl <= maskedWrite(baudCtl, wrByte, BAUD_WMASK, baudWr);
			divLo <= maskedWrite(divLo, wrByte, 8'hFF, divLoWr);
			divHi <= maskedWrite(divHi, wrByte, 8'hFF, divHiWr);
			// Delayed one cycle so the reload sees the new divisor
			divRestart <= divLoWr || divHiWr; // [R4] [R5]
		end
	end

	assign portCfg = '{txCtl: txCtl, rxCtl: rxCtl, baudCtl: baudCtl};

	// ----------------------------------------------------------------
	// Interrupt flags
	// ----------------------------------------------------------------
	wire [7:0] flagEvent = putBit(putBit(putBit(putBit(8'h00, FLAG_RX_CH2, ch2RxEvent),
		FLAG_TX_CH2, ch2TxEvent), FLAG_RX_CH1, rxCharValid), FLAG_TX_CH1, txTaken); // [R11]
	wire [7:0] flagClear = flagWr ? (wrByte & FLAG_MASK) : 8'h00;
	// Set wins over write-one-to-clear in the same cycle
	wire [7:0] next_flag = (flag & ~flagClear) | flagEvent; // [R11]

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			flag <= FLAG_RST;
			enable <= FLAG_RST;
		end
		else
		begin
			flag <= next_flag;
			enable <= maskedWrite(enable, wrByte, FLAG_MASK, enableWr); // [R11]
		end
	end

	assign irq = |(flag & enable);

	// ----------------------------------------------------------------
	// Baud rate generator
	// ----------------------------------------------------------------
	wire ubg_baud_cfg_t baudCfg = '{sync: txCtl[TX_MODE_SYNC], wide: baudCtl[BAUD_WIDE],
		highSpeed: txCtl[TX_HIGH_SPEED]}; // [R12] [R13]

	ubg_baud_gen #(
		.PRE_HS8(PRE_HS8),
		.PRE_HS16(PRE_HS16)
	) u_baud (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.restart(divRestart),
		.divLo(divLo),
		.divHi(divHi),
		.cfg(baudCfg),
		.tick(baudTick)
	);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_rx_read_data: assert property (@(posedge clk_sys) disable iff (!nrst) // [R1]
		(rxRead) |-> (wb_dat_o == {24'h00_0000, $past(rxHold.data)}))
		else $error("Receive read did not return the held low byte");

	a_rx_hold_load: assert property (@(posedge clk_sys) disable iff (!nrst) // [R2]
		rxCharValid |=> (rxFull && rxHold == $past(rxChar)))
		else $error("Arriving character not held");

	a_rx_hold_keep: assert property (@(posedge clk_sys) disable iff (!nrst) // [R2]
		(rxFull && !rxCharValid && !rxRead) |=> (rxFull && $stable(rxHold)))
		else $error("Held character lost before it was read");

	a_tx_load: assert property (@(posedge clk_sys) disable iff (!nrst) // [R3]
		txWr |=> (txFull && txBuf.data == $past(wrByte) && txBuf.ninth == $past(txCtl[TX_NINTH])))
		else $error("Transmit write not buffered with its ninth bit");

	a_tx_drain: assert property (@(posedge clk_sys) disable iff (!nrst) // [R3]
		(txTaken && !txWr) |=> (!txFull ##1 (txFull == $past(txWr))))
		else $error("Transmit buffer not freed when taken");

	a_flag_sticky: assert property (@(posedge clk_sys) disable iff (!nrst) // [R11]
		(txTaken || (flag[FLAG_TX_CH1] && !(flagWr && wrByte[FLAG_TX_CH1])))
		|=> flag[FLAG_TX_CH1])
		else $error("Transmit flag missed or cleared early");

	a_irq_mask: assert property (@(posedge clk_sys) disable iff (!nrst) // [R11]
		(rxCharValid && enable[FLAG_RX_CH1]) |=> irq [*1] ##0 flag[FLAG_RX_CH1])
		else $error("Enabled receive flag gave no interrupt");

	a_div_restart: assert property (@(posedge clk_sys) disable iff (!nrst) // [R4] [R5]
		(divLoWr || divHiWr) |=> (divRestart ##1 !divRestart || divLoWr || divHiWr))
		else $error("Divisor write did not restart the generator");

	a_rx_read_free: assert property (@(posedge clk_sys) disable iff (!nrst) // [R2]
		(rxRead && !rxCharValid) |=> !rxFull)
		else $error("Receive buffer still full after read");

	a_rx_read_upper: assert property (@(posedge clk_sys) disable iff (!nrst) // [R1]
		rxRead |-> (wb_dat_o[31:8] == 24'h00_0000))
		else $error("Receive read carries bits above the low byte");

	a_overrun_set: assert property (@(posedge clk_sys) disable iff (!nrst) // [R2]
		overrunSet |=> (overrun && rxFull))
		else $error("Arrival while full did not flag overrun");

	a_overrun_clear: assert property (@(posedge clk_sys) disable iff (!nrst) // [R2]
		(overrun && !rxCtl[RX_CONT_EN] && !overrunSet) |=> !overrun)
		else $error("Overrun kept with continuous receive off");

	a_tx_keep: assert property (@(posedge clk_sys) disable iff (!nrst) // [R3]
		(txFull && !txWr) |=> $stable(txBuf))
		else $error("Waiting transmit character changed");

	a_tx_wait_full: assert property (@(posedge clk_sys) disable iff (!nrst) // [R3]
		(txFull && !txCharTake) |=> txFull)
		else $error("Transmit buffer emptied without a take");

	a_tx_flag_set: assert property (@(posedge clk_sys) disable iff (!nrst) // [R11]
		txTaken |=> flag[FLAG_TX_CH1])
		else $error("Transmit take did not set its flag");

	a_rx_flag_set: assert property (@(posedge clk_sys) disable iff (!nrst) // [R11]
		rxCharValid |=> flag[FLAG_RX_CH1])
		else $error("Arrival did not set the receive flag");

	a_ch2_flags: assert property (@(posedge clk_sys) disable iff (!nrst) // [R11]
		(ch2RxEvent && ch2TxEvent) |=> (flag[FLAG_RX_CH2] && flag[FLAG_TX_CH2]))
		else $error("Second channel events not flagged");

	a_flag_clear: assert property (@(posedge clk_sys) disable iff (!nrst) // [R11]
		(flagWr && wrByte[FLAG_RX_CH2] && !ch2RxEvent) |=> !flag[FLAG_RX_CH2])
		else $error("Write of one did not clear the flag");

	a_enable_write: assert property (@(posedge clk_sys) disable iff (!nrst) // [R11]
		enableWr |=> (enable == ($past(wrByte) & FLAG_MASK)))
		else $error("Enable register write not stored");

	a_div_low_write: assert property (@(posedge clk_sys) disable iff (!nrst) // [R4]
		divLoWr |=> (divLo == $past(wrByte)))
		else $error("Low divisor byte not stored");

	a_div_high_write: assert property (@(posedge clk_sys) disable iff (!nrst) // [R5]
		divHiWr |=> (divHi == $past(wrByte)))
		else $error("High divisor byte not stored");

endmodule : ubg_buffers

/* File: hdl/ubg_pkg.sv */
// Constants and carrier types for the serial port buffers and baud generator
package ubg_pkg;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam int ADR_W = 8;
	localparam logic [7:0] ADR_RX_DATA = 8'h00;
	localparam logic [7:0] ADR_TX_DATA = 8'h04;
	localparam logic [7:0] ADR_DIV_LOW = 8'h08;
	localparam logic [7:0] ADR_DIV_HIGH = 8'h0C;
	localparam logic [7:0] ADR_RX_STAT = 8'h10;
	localparam logic [7:0] ADR_TX_STAT = 8'h14;
	localparam logic [7:0] ADR_BAUD_CTL = 8'h18;
	localparam logic [7:0] ADR_FLAG = 8'h1C;
	localparam logic [7:0] ADR_ENABLE = 8'h20;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int TX_SHIFT_EMPTY = 1;
	localparam int TX_NINTH = 0;
	localparam int TX_HIGH_SPEED = 2;
	localparam int TX_MODE_SYNC = 4;
	localparam int RX_CONT_EN = 4;
	localparam int RX_FRAME_ERR = 2;
	localparam int RX_OVERRUN = 1;
	localparam int RX_NINTH = 0;
	localparam int BAUD_RX_IDLE = 6;
	localparam int BAUD_WIDE = 3;
	localparam int FLAG_RX_CH2 = 7;
	localparam int FLAG_TX_CH2 = 6;
	localparam int FLAG_RX_CH1 = 5;
	localparam int FLAG_TX_CH1 = 4;

	// ----------------------------------------------------------------
	// Write masks and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] TX_STAT_WMASK = 8'hFD;
	localparam logic [7:0] RX_STAT_WMASK = 8'hF8;
	localparam logic [7:0] BAUD_WMASK = 8'h1B;
	localparam logic [7:0] FLAG_MASK = 8'hF0;
	localparam logic [7:0] TX_STAT_RST = 8'h00;
	localparam logic [7:0] RX_STAT_RST = 8'h00;
	localparam logic [7:0] BAUD_RST = 8'h00;
	localparam logic [7:0] DIV_RST = 8'h00;
	localparam logic [7:0] DATA_RST = 8'h00;
	localparam logic [7:0] FLAG_RST = 8'h00;

	// ----------------------------------------------------------------
	// Prescale factors
	// ----------------------------------------------------------------
	localparam int PRE_ASYNC_NARROW = 64;
	localparam int PRE_ASYNC_WIDE = 16;
	localparam int PRE_SYNC = 4;
	localparam int PRE_MAX = 64;

	// ----------------------------------------------------------------
	// Carrier types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic frameErr;
		logic ninth;
		logic [7:0] data;
	} ubg_rx_char_t;

	typedef struct packed {
		logic ninth;
		logic [7:0] data;
	} ubg_tx_char_t;

	typedef struct packed {
		logic sync;
		logic wide;
		logic highSpeed;
	} ubg_baud_cfg_t;

	typedef struct packed {
		logic [7:0] txCtl;
		logic [7:0] rxCtl;
		logic [7:0] baudCtl;
	} ubg_port_cfg_t;

endpackage : ubg_pkg

/* File: sim/ubg_buffers_tb_top.sv */
// Self-checking bench for the serial port buffers and baud generator
`timescale 1ns/1ps
module ubg_buffers_tb_top;
	import ubg_pkg::*;
	localparam int HS8 = 8;
	localparam int HS16 = 32;
	logic clk_sys, nrst, wbCyc, wbStb, wbWe, wbAck, irq, ch2RxEvent, ch2TxEvent;
	logic [7:0] wbAdr;
	logic [3:0] wbSel;
	logic [31:0] wbDatI, wbDatO;
	logic rxCharValid, txCharValid, txCharTake, shiftEmpty, rxIdle, baudTick;
	ubg_rx_char_t rxChar;
	ubg_tx_char_t txChar;
	ubg_port_cfg_t portCfg;
	int badCount = 0;
	int numChecks = 0;
	ubg_buffers #(.PRE_HS8(HS8), .PRE_HS16(HS16)) uut (.clk_sys(clk_sys), .nrst(nrst),
		.wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
		.wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
		.irq(irq), .rxCharValid(rxCharValid), .rxChar(rxChar), .txCharValid(txCharValid),
		.txChar(txChar), .txCharTake(txCharTake), .shiftEmpty(shiftEmpty), .rxIdle(rxIdle),
		.ch2RxEvent(ch2RxEvent), .ch2TxEvent(ch2TxEvent), .portCfg(portCfg), .baudTick(baudTick));
	ubg_line_model line (.clk_sys(clk_sys), .txCharValid(txCharValid), .txChar(txChar),
		.rxCharValid(rxCharValid), .rxChar(rxChar), .txCharTake(txCharTake),
		.shiftEmpty(shiftEmpty), .rxIdle(rxIdle));
	// ----
	// Common tasks
	// ----
	task automatic stopTest();
		$display("Checks %0d mismatches %0d", numChecks, badCount);
		if (badCount == 0 && numChecks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : stopTest
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		numChecks++;
		if (seen !== exp)
		begin
			badCount++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic hang(input string what);
		badCount++;
		$display("CHECK FAILED %s expected response seen none", what);
		stopTest();
	endtask : hang
	task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [7:0] d,
		output logic [31:0] r);
		int n;
		n = 0;
		@(posedge clk_sys);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= we;
		wbAdr <= adr;
		wbSel <= 4'h1;
		wbDatI <= {24'h00_0000, d};
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while (wbAck !== 1'b1 && n < 20);
		r = wbDatO;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		wbWe <= 1'b0;
		if (n >= 20)
			hang("bus ack");
	endtask : wb_cycle
	task automatic wr(input logic [7:0] adr, input logic [7:0] d);
		logic [31:0] r;
		wb_cycle(1'b1, adr, d, r);
	endtask : wr
	task automatic rd_chk(input string what, input logic [7:0] adr, input logic [31:0] exp);
		logic [31:0] r;
		wb_cycle(1'b0, adr, 8'h00, r);
		check(what, r, exp);
	endtask : rd_chk
	task automatic count_ticks(output int n);
		n = 0;
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while (baudTick !== 1'b1 && n < 5000);
		if (n >= 5000)
			hang("baud tick");
	endtask : count_ticks
	task automatic wait_take(input int k);
		int n;
		for (n = 0; n < 200 && line.takeCount != k; n++)
			@(posedge clk_sys);
		if (n >= 200)
			hang("transmit take");
	endtask : wait_take
	// ----
	// Scenarios
	// ----
	task automatic test_reset();
		logic [7:0] exp [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h40, 8'h00,
			8'h00, 8'h00};
		for (int i = 0; i < 10; i++)
			rd_chk("reset value", 8'(i * 4), {24'h00_0000, exp[i]});
		wr(ADR_BAUD_CTL, 8'hFF);
		rd_chk("baud ctl", ADR_BAUD_CTL, {24'h00_0000, BAUD_WMASK | 8'h40});
		wr(ADR_BAUD_CTL, 8'h00);
		$display("test reset done");
	endtask : test_reset
	task automatic test_rx();
		wr(ADR_FLAG, 8'hF0);
		line.send_char('{frameErr: 1'b0, ninth: 1'b1, data: 8'hA5});
		rd_chk("rx status", ADR_RX_STAT, 32'h0000_0001);
		rd_chk("rx flag", ADR_FLAG, 32'h0000_0020);
		wr(ADR_RX_DATA, 8'hFF);
		fork
			line.send_char('{frameErr: 1'b1, ninth: 1'b0, data: 8'h5A});
			rd_chk("rx held", ADR_RX_DATA, 32'h0000_00A5);
		join
		rd_chk("rx next", ADR_RX_DATA, 32'h0000_005A);
		rd_chk("rx status next", ADR_RX_STAT, 32'h0000_0004);
		wr(ADR_RX_STAT, 8'h10);
		line.send_char('{frameErr: 1'b0, ninth: 1'b0, data: 8'h01});
		line.send_char('{frameErr: 1'b0, ninth: 1'b1, data: 8'h02});
		rd_chk("rx overrun", ADR_RX_STAT, 32'h0000_0013);
		wr(ADR_RX_STAT, 8'h00);
		rd_chk("overrun clear", ADR_RX_STAT, 32'h0000_0001);
		rd_chk("rx last", ADR_RX_DATA, 32'h0000_0002);
		$display("test rx done");
	endtask : test_rx
	task automatic test_tx();
		wr(ADR_FLAG, 8'hF0);
		wr(ADR_TX_STAT, 8'h01);
		wr(ADR_TX_DATA, 8'h3C);
		wait_take(1);
		rd_chk("tx flag", ADR_FLAG, 32'h0000_0010);
		rd_chk("tx stat shifting", ADR_TX_STAT, 32'h0000_0001);
		wr(ADR_TX_STAT, 8'h00);
		wr(ADR_TX_DATA, 8'hC3);
		check("tx first", {23'h0, line.lastTx}, 32'h0000_013C);
		@(negedge clk_sys);
		check("tx waiting", {31'h0, txCharValid}, 32'h0000_0001);
		wait_take(2);
		@(negedge clk_sys);
		check("tx second", {23'h0, line.lastTx}, 32'h0000_00C3);
		$display("test tx done");
	endtask : test_tx
	task automatic test_irq();
		wr(ADR_FLAG, 8'hF0);
		wr(ADR_ENABLE, 8'h20);
		ch2RxEvent <= 1'b1;
		ch2TxEvent <= 1'b1;
		@(posedge clk_sys);
		ch2RxEvent <= 1'b0;
		ch2TxEvent <= 1'b0;
		rd_chk("ch2 flags", ADR_FLAG, 32'h0000_00C0);
		check("irq masked", {31'h0, irq}, 32'h0000_0000);
		line.send_char('{frameErr: 1'b0, ninth: 1'b0, data: 8'h11});
		@(negedge clk_sys);
		check("irq raised", {31'h0, irq}, 32'h0000_0001);
		wr(ADR_FLAG, 8'h20);
		@(negedge clk_sys);
		check("irq cleared", {31'h0, irq}, 32'h0000_0000);
		rd_chk("flags left", ADR_FLAG, 32'h0000_00C0);
		wr(ADR_ENABLE, 8'hF0);
		@(negedge clk_sys);
		check("irq ch2", {31'h0, irq}, 32'h0000_0001);
		wr(ADR_FLAG, 8'hF0);
		rd_chk("rx data", ADR_RX_DATA, 32'h0000_0011);
		$display("test irq done");
	endtask : test_irq
	task automatic test_baud();
		logic [7:0] txs [6] = '{8'h00, 8'h00, 8'h10, 8'h14, 8'h04, 8'h04};
		logic [7:0] bcs [6] = '{8'h00, 8'h08, 8'h00, 8'h08, 8'h00, 8'h08};
		logic [7:0] his [6] = '{8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00};
		logic [7:0] los [6] = '{8'h02, 8'h02, 8'h03, 8'h05, 8'h03, 8'h03};
		int per [6] = '{192, 4144, 16, 24, HS8 * 4, HS16 * 4};
		int n;
		for (int i = 0; i < 6; i++)
		begin
			wr(ADR_TX_STAT, txs[i]);
			wr(ADR_BAUD_CTL, bcs[i]);
			// Restarting byte goes last; alternate so both bytes restart
			if (i % 2 == 1)
				wr(ADR_DIV_LOW, los[i]);
			wr(ADR_DIV_HIGH, his[i]);
			if (i % 2 == 0)
				wr(ADR_DIV_LOW, los[i]);
			count_ticks(n);
			check("first tick", 32'(n), 32'(per[i] + 2));
			count_ticks(n);
			check("baud period", 32'(n), 32'(per[i]));
			check("port cfg", {8'h00, portCfg}, {8'h00, txs[i], 8'h00, bcs[i]});
		end
		$display("test baud done");
	endtask : test_baud
	// ----
	// Clock, reset and sequence
	// ----
	initial
	begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	initial
	begin
		#400_000;
		hang("run time");
	end
	initial
	begin
		nrst = 1'b0;
		wbCyc = 1'b0;
		wbStb = 1'b0;
		wbWe = 1'b0;
		wbAdr = 8'h00;
		wbSel = 4'h0;
		wbDatI = 32'h0000_0000;
		ch2RxEvent = 1'b0;
		ch2TxEvent = 1'b0;
		repeat (8) @(posedge clk_sys);
		nrst <= 1'b1;
		test_reset();
		test_rx();
		test_tx();
		test_irq();
		test_baud();
		stopTest();
	end
endmodule : ubg_buffers_tb_top

/* File: sim/ubg_line_model.sv */
// Line-side partner: feeds received characters and drains the transmit buffer
`timescale 1ns/1ps
module ubg_line_model (
	input wire logic clk_sys,
	input wire logic txCharValid,
	input wire ubg_pkg::ubg_tx_char_t txChar,
	output logic rxCharValid,
	output ubg_pkg::ubg_rx_char_t rxChar,
	output logic txCharTake,
	output logic shiftEmpty,
	output logic rxIdle
);
	import ubg_pkg::*;
	ubg_tx_char_t lastTx;
	int takeCount;
	initial
	begin
		rxCharValid = 1'b0;
		rxChar = '0;
		txCharTake = 1'b0;
		shiftEmpty = 1'b1;
		rxIdle = 1'b1;
		lastTx = '0;
		takeCount = 0;
	end
	// ----
	// Receive: shift gap, one-cycle pulse, then garbled bus
	// ----
	task automatic send_char(input ubg_rx_char_t c);
		rxIdle <= 1'b0;
		repeat (40) @(posedge clk_sys);
		rxCharValid <= 1'b1;
		rxChar <= c;
		@(posedge clk_sys);
		rxCharValid <= 1'b0;
		rxChar <= ~c;
		rxIdle <= 1'b1;
	endtask : send_char
	// ----
	// Transmit: take only when shifter empty, shift for a while
	// ----
	always
	begin
		@(posedge clk_sys);
		if (txCharValid === 1'b1 && shiftEmpty)
		begin
			repeat (5) @(posedge clk_sys);
			txCharTake <= 1'b1;
			shiftEmpty <= 1'b0;
			@(posedge clk_sys);
			lastTx <= txChar;
			takeCount <= takeCount + 1;
			txCharTake <= 1'b0;
			repeat (60) @(posedge clk_sys);
			shiftEmpty <= 1'b1;
		end
	end
endmodule : ubg_line_model
